// ==== sdd_pkg.sv ====
`default_nettype none

package sdd_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 50;
	localparam int MIN_DELAY_NS     = 100000;
	localparam int MIN_DELAY_CYC    = (MIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PGA_SETTLE_NS    = 4000000;
	localparam int PGA_SETTLE_CYC   = PGA_SETTLE_NS / CLK_PERIOD_NS;
	localparam int TIMER_STEP_NS    = 4000000;
	localparam int TIMER_STEP_CYC   = TIMER_STEP_NS / CLK_PERIOD_NS;
	localparam int DETECT_MIN_HZ    = 300000;
	localparam int DETECT_WIN_CYC   = 4096;
	localparam int DETECT_THRESH    = (DETECT_MIN_HZ / 1000) * DETECT_WIN_CYC * CLK_PERIOD_NS
		/ 1000000 + 1;
	localparam int INT_OSC_DIV      = 4;
	localparam int MOD_DIV          = 16;
	localparam int SETTLE_WORDS     = 4;

	// ----------------------------------------------------------------
	// Filter layout
	// ----------------------------------------------------------------
	localparam int ACC_W            = 72;
	localparam int RATIO_W          = 17;
	localparam int WORD_W           = 24;
	localparam int RATE_W           = 5;
	localparam logic [RATE_W-1:0] RATE_LAST = 5'h13;

	// Decimation ratios at a 307.2 kHz modulator rate, indexed by rate code
	localparam logic [RATIO_W-1:0] RATIO_TABLE [0:19] = '{
		17'h1e000, 17'h0f000, 17'h07800, 17'h03c00, 17'h01e00,
		17'h00f00, 17'h00780, 17'h003c0, 17'h001e0, 17'h000f0,
		17'h00078, 17'h00c00, 17'h00600, 17'h00300, 17'h00180,
		17'h000c0, 17'h00060, 17'h00133, 17'h0009a, 17'h0004d};

	// ----------------------------------------------------------------
	// Input selection
	// ----------------------------------------------------------------
	localparam logic [2:0] CH_SUPPLY_MON = 3'h4;
	localparam logic [2:0] CH_TEMP       = 3'h5;
	localparam logic [2:0] GAIN_UNITY    = 3'h0;

	typedef enum logic [3:0] {
		SDD_ST_PGA   = 4'b0001,
		SDD_ST_TIMER = 4'b0010,
		SDD_ST_MIN   = 4'b0100,
		SDD_ST_RUN   = 4'b1000
	} sdd_state_e;

endpackage

`default_nettype wire

// ==== sdd_word_buffer.sv ====
`default_nettype none

module sdd_word_buffer #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [PTR_W:0]   count_q;
	wire              doWrite = inValid && inReady;
	wire              doRead  = outValid && outReady;

	// Flags from occupancy
	assign inReady  = (count_q != (PTR_W+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];

	// Storage and pointers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			if (doWrite) begin
				mem_q[wrPtr_q] <= inData;
				wrPtr_q        <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (doRead) begin
				rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (PTR_W+1)'(doWrite) - (PTR_W+1)'(doRead);
		end
	end

endmodule // sdd_word_buffer

`default_nettype wire

// ==== sdd_rate_ctrl.sv ====
// What this block does
// - Sinc4 filter with programmable decimation ratio
// - Codes 00..0A give 2.5 to 2560 Sps
// - Codes 0B..13 give remaining listed rates
// - Word rate scales with converter clock
// - Channel write resets modulator and filter
// - First word after channel change waits four periods
// - Gain change also waits four periods
// - Ready output low when word available
// - Clock above 300 kHz selects external clock
// - Seven amplifying gains 2x to 128x
// - Unity gain bypasses the amplifier
// - Differential channels plus supply and temperature
// - Word shifted out 24-bit MSB first
// - Minimum 100 us delay after channel change
`default_nettype none

module sdd_rate_ctrl #(
	parameter int PGA_SETTLE_CYC = sdd_pkg::PGA_SETTLE_CYC,
	parameter int TIMER_STEP_CYC = sdd_pkg::TIMER_STEP_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic [sdd_pkg::RATE_W-1:0] word_rate_select,
	input  wire logic [2:0]                 channelSel,
	input  wire logic [2:0]                 gainSel,
	input  wire logic [7:0]                 delayTimer,
	input  wire logic                       crystal_or_clock_in,
	input  wire logic                       modBit,
	input  wire logic                       serialClkIn,
	output logic                            serial_out_ready_n,
	output logic                            modTick,
	output logic                            modReset,
	output logic [2:0]                      muxSelect,
	output logic [2:0]                      gain_amplifier,
	output logic                            ampBypass,
	output logic                            intOscEnable,
	output logic                            extClockSelected
);

	localparam int AW = sdd_pkg::ACC_W;
	localparam int RW = sdd_pkg::RATIO_W;
	localparam int WW = sdd_pkg::WORD_W;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Rate code to decimation ratio, illegal codes fall back to code 00
	function automatic logic [RW-1:0] ratioOf(input logic [sdd_pkg::RATE_W-1:0] code);
		ratioOf = (code <= sdd_pkg::RATE_LAST) ? sdd_pkg::RATIO_TABLE[code]
			: sdd_pkg::RATIO_TABLE[0];
	endfunction

	// Smallest n with 2**n >= r
	function automatic int log2Ceil(input logic [RW-1:0] r);
		int n;
		n = 0;
		for (int i = 0; i < RW; i++) begin
			if ((RW+1)'(1) << i < (RW+1)'(r)) begin
				n = i + 1;
			end
		end
		log2Ceil = n;
	endfunction

	// ----------------------------------------------------------------
	// External clock sampling and detection
	// ----------------------------------------------------------------
	logic        extSync1_q, extSync2_q, extPrev_q;
	logic [12:0] winCnt_q;
	logic [12:0] edgeCnt_q;
	logic        detectDone_q;
	logic        extSel_q;
	wire         extRise = extSync2_q && !extPrev_q;

	// Two-stage synchroniser, edge detect on second stage only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			extSync1_q <= 1'b0;
			extSync2_q <= 1'b0;
			extPrev_q  <= 1'b0;
		end else begin
			extSync1_q <= crystal_or_clock_in;
			extSync2_q <= extSync1_q;
			extPrev_q  <= extSync2_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			winCnt_q     <= '0;
			edgeCnt_q    <= '0;
			detectDone_q <= 1'b0;
			extSel_q     <= 1'b0;
		end else if (!detectDone_q) begin
			winCnt_q  <= winCnt_q + 1'b1;
			edgeCnt_q <= edgeCnt_q + 13'(extRise);
			if (winCnt_q == 13'(sdd_pkg::DETECT_WIN_CYC - 1)) begin
				detectDone_q <= 1'b1;
				extSel_q     <= (edgeCnt_q >= 13'(sdd_pkg::DETECT_THRESH));
			end
		end
	end

	assign extClockSelected = extSel_q;
	assign intOscEnable     = !extSel_q;

	// ----------------------------------------------------------------
	// Converter and modulator tick dividers
	// ----------------------------------------------------------------
	logic [2:0] oscCnt_q;
	logic [3:0] modCnt_q;
	wire        oscTick = (oscCnt_q == 3'(sdd_pkg::INT_OSC_DIV - 1));
	wire        convTick = detectDone_q && (extSel_q ? extRise : oscTick);
	wire        modTickW = convTick && (modCnt_q == 4'(sdd_pkg::MOD_DIV - 1));

	// Dividers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			oscCnt_q <= '0;
			modCnt_q <= '0;
		end else begin
			oscCnt_q <= oscTick ? '0 : oscCnt_q + 1'b1;
			if (convTick) begin
				modCnt_q <= modCnt_q + 1'b1;
			end
		end
	end

	assign modTick = modTickW;

	// ----------------------------------------------------------------
	// Input selection and change detection
	// ----------------------------------------------------------------
	logic [2:0] chanSeen_q, gainSeen_q;
	wire        chanChanged = (channelSel != chanSeen_q);
	wire        gainChanged = (gainSel != gainSeen_q);
	wire        internalSel = (channelSel == sdd_pkg::CH_SUPPLY_MON)
		|| (channelSel == sdd_pkg::CH_TEMP);

	assign muxSelect      = channelSel;
	assign gain_amplifier = internalSel ? sdd_pkg::GAIN_UNITY : gainSel;
	assign ampBypass      = (gain_amplifier == sdd_pkg::GAIN_UNITY);

	// ----------------------------------------------------------------
	// Settling sequencer
	// ----------------------------------------------------------------
	sdd_pkg::sdd_state_e state_q;
	logic [16:0]         delayCnt_q;
	logic [7:0]          stepsLeft_q;
	logic [2:0]          wordsSeen_q;
	wire                 restart = chanChanged || gainChanged;
	wire                 delayEnd;
	logic                decTick;

	assign delayEnd = (state_q == sdd_pkg::SDD_ST_PGA)
		? (delayCnt_q == 17'(PGA_SETTLE_CYC - 1))
		: (state_q == sdd_pkg::SDD_ST_TIMER)
		? (delayCnt_q == 17'(TIMER_STEP_CYC - 1))
		: (delayCnt_q == 17'(sdd_pkg::MIN_DELAY_CYC - 1));

	// restart on channel or gain write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chanSeen_q  <= '0;
			gainSeen_q  <= '0;
			state_q     <= sdd_pkg::SDD_ST_PGA;
			delayCnt_q  <= '0;
			stepsLeft_q <= '0;
			wordsSeen_q <= '0;
		end else if (restart) begin
			chanSeen_q  <= channelSel;
			gainSeen_q  <= gainSel;
			state_q     <= sdd_pkg::SDD_ST_PGA;
			delayCnt_q  <= '0;
			wordsSeen_q <= '0;
		end else begin
			delayCnt_q <= (delayEnd || state_q == sdd_pkg::SDD_ST_RUN) ? '0
				: delayCnt_q + 1'b1;
			unique case (state_q)
				sdd_pkg::SDD_ST_PGA: begin
					stepsLeft_q <= delayTimer;
					if (delayEnd) begin
						state_q <= (delayTimer == '0) ? sdd_pkg::SDD_ST_MIN
							: sdd_pkg::SDD_ST_TIMER;
					end
				end
				sdd_pkg::SDD_ST_TIMER: begin
					if (delayEnd) begin
						stepsLeft_q <= stepsLeft_q - 1'b1;
						if (stepsLeft_q == 8'h01) begin
							state_q <= sdd_pkg::SDD_ST_MIN;
						end
					end
				end
				sdd_pkg::SDD_ST_MIN: begin
					if (delayEnd) begin
						state_q <= sdd_pkg::SDD_ST_RUN;
					end
				end
				sdd_pkg::SDD_ST_RUN: begin
					if (decTick && wordsSeen_q != 3'(sdd_pkg::SETTLE_WORDS)) begin
						wordsSeen_q <= wordsSeen_q + 1'b1;
					end
				end
			endcase
		end
	end

	wire running = (state_q == sdd_pkg::SDD_ST_RUN) && !restart;
	// modulator held in reset until conversion starts
	assign modReset = !running;

	// ----------------------------------------------------------------
	// Sinc4 decimation filter
	// ----------------------------------------------------------------
	logic signed [AW-1:0] integ_q [4];
	logic signed [AW-1:0] combDly_q [4];
	logic signed [AW-1:0] combOut [5];
	logic [RW-1:0]        decCnt_q;
	wire  [RW-1:0]        ratio   = ratioOf(word_rate_select);
	wire  signed [AW-1:0] sample  = modBit ? AW'(1) : -AW'(1);
	wire  [6:0]           shiftBy = 7'(4 * log2Ceil(ratio) - (WW - 1));
	wire  signed [AW-1:0] scaled  = combOut[4] >>> shiftBy;
	wire  signed [AW-1:0] posMax  = AW'((1 << (WW - 1)) - 1);
	wire  signed [AW-1:0] negMax  = -AW'(1 << (WW - 1));
	wire  [WW-1:0]        wordVal = (scaled > posMax) ? WW'(posMax)
		: (scaled < negMax) ? WW'(negMax) : scaled[WW-1:0];

	assign decTick    = running && modTickW && (decCnt_q == ratio - 1'b1);
	assign combOut[0] = integ_q[3];

	// comb chain, differences at word rate
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gComb
			assign combOut[g+1] = combOut[g] - combDly_q[g];
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			decCnt_q <= '0;
			for (int i = 0; i < 4; i++) begin
				integ_q[i]   <= '0;
				combDly_q[i] <= '0;
			end
		end else if (!running) begin
			decCnt_q <= '0;
			for (int i = 0; i < 4; i++) begin
				integ_q[i]   <= '0;
				combDly_q[i] <= '0;
			end
		end else if (modTickW) begin
			decCnt_q   <= decTick ? '0 : decCnt_q + 1'b1;
			integ_q[0] <= integ_q[0] + sample;
			for (int i = 1; i < 4; i++) begin
				integ_q[i] <= integ_q[i] + integ_q[i-1];
			end
			if (decTick) begin
				for (int i = 0; i < 4; i++) begin
					combDly_q[i] <= combOut[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Word capture, buffer and serial output
	// ----------------------------------------------------------------
	logic [WW-1:0] word_q;
	logic          wordValid_q;
	logic          bufReady, bufValid;
	logic [WW-1:0] bufData;
	logic [4:0]    bitsLeft_q;
	// Shifter free, buffer may hand over
	wire           shiftIdle = (bitsLeft_q == '0);
	wire           settledWord = decTick && (wordsSeen_q >= 3'(sdd_pkg::SETTLE_WORDS - 1));

	// Pending word, newest overwrites while buffer is full
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_q      <= '0;
			wordValid_q <= 1'b0;
		end else if (settledWord) begin
			word_q      <= wordVal;
			wordValid_q <= 1'b1;
		end else if (bufReady || restart) begin
			wordValid_q <= 1'b0;
		end
	end

	sdd_word_buffer #(
		.WIDTH (WW),
		.DEPTH (2)
	) uBuffer (
		.clk      (clk),
		.arst_n   (arst_n),
		.inData   (word_q),
		.inValid  (wordValid_q),
		.inReady  (bufReady),
		.outData  (bufData),
		.outValid (bufValid),
		.outReady (shiftIdle)
	);

	logic          sclkSync1_q, sclkSync2_q, sclkPrev_q;
	logic [WW-1:0] shift_q;
	logic          outPin_q;
	wire           sclkRise  = sclkSync2_q && !sclkPrev_q;

	// serial shifter, MSB first on host clock rise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sclkSync1_q <= 1'b0;
			sclkSync2_q <= 1'b0;
			sclkPrev_q  <= 1'b0;
			shift_q     <= '0;
			bitsLeft_q  <= '0;
			outPin_q    <= 1'b1;
		end else begin
			sclkSync1_q <= serialClkIn;
			sclkSync2_q <= sclkSync1_q;
			sclkPrev_q  <= sclkSync2_q;
			if (shiftIdle && bufValid) begin
				shift_q    <= bufData;
				bitsLeft_q <= 5'(WW);
				outPin_q   <= 1'b0;
			end else if (!shiftIdle && sclkRise) begin
				outPin_q   <= shift_q[WW-1];
				shift_q    <= {shift_q[WW-2:0], 1'b0};
				bitsLeft_q <= bitsLeft_q - 1'b1;
			end else if (shiftIdle) begin
				outPin_q <= 1'b1;
			end
		end
	end

	assign serial_out_ready_n = outPin_q;

endmodule // sdd_rate_ctrl

`default_nettype wire

// ==== sdd_rate_ctrl_asserts.sv ====
`default_nettype none

module sdd_rate_ctrl_chk #(
	parameter int PGA_SETTLE_CYC = sdd_pkg::PGA_SETTLE_CYC,
	parameter int TIMER_STEP_CYC = sdd_pkg::TIMER_STEP_CYC
) (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [2:0] channelSel,
	input wire logic [2:0] gainSel,
	input wire logic [7:0] delayTimer,
	input wire logic       serial_out_ready_n,
	input wire logic       modTick,
	input wire logic       modReset,
	input wire logic [2:0] muxSelect,
	input wire logic [2:0] gain_amplifier,
	input wire logic       ampBypass,
	input wire logic       intOscEnable,
	input wire logic       extClockSelected
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------
	// Helpers
	// ------
	int unsigned holdCnt_q;
	int unsigned upCnt_q;

	// Reset hold length, cycles since release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			holdCnt_q <= 0;
			upCnt_q   <= 0;
		end else begin
			holdCnt_q <= modReset ? holdCnt_q + 1 : 0;
			if (upCnt_q < 5000)
				upCnt_q <= upCnt_q + 1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// ------
	// Properties
	// ------
	property p_mux;
		muxSelect == channelSel;
	endproperty
	a_mux: assert property (p_mux) else $error("mux select off");
	property p_gain;
		channelSel < 3'h4 |-> gain_amplifier == gainSel;
	endproperty
	a_gain: assert property (p_gain) else $error("gain not passed");
	property p_int;
		channelSel inside {3'h4, 3'h5} |-> gain_amplifier == 3'h0;
	endproperty
	a_int: assert property (p_int) else $error("internal input not unity");
	property p_byp;
		ampBypass == (gain_amplifier == 3'h0);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass wrong");
	property p_osc;
		intOscEnable != extClockSelected;
	endproperty
	a_osc: assert property (p_osc) else $error("clock source clash");
	property p_detect;
		upCnt_q < 4090 |-> intOscEnable && serial_out_ready_n && !modTick;
	endproperty
	a_detect: assert property (p_detect) else $error("early activity");
	property p_chg;
		$changed(channelSel) || $changed(gainSel) |-> ##[0:2] modReset;
	endproperty
	a_chg: assert property (p_chg) else $error("no filter reset");
	property p_tick;
		modTick && intOscEnable && !modReset |=> (!modTick)[*8] ##56 (modTick || modReset);
	endproperty
	a_tick: assert property (p_tick) else $error("tick spacing");
	property p_wait;
		$fell(modReset) |-> holdCnt_q >= PGA_SETTLE_CYC + delayTimer * TIMER_STEP_CYC
			+ sdd_pkg::MIN_DELAY_CYC;
	endproperty
	a_wait: assert property (p_wait) else $error("start delay short");
endmodule // sdd_rate_ctrl_chk

bind sdd_rate_ctrl sdd_rate_ctrl_chk #(
	.PGA_SETTLE_CYC(PGA_SETTLE_CYC),
	.TIMER_STEP_CYC(TIMER_STEP_CYC)
) u_chk (
	.clk(clk), .arst_n(arst_n), .channelSel(channelSel), .gainSel(gainSel),
	.delayTimer(delayTimer), .serial_out_ready_n(serial_out_ready_n),
	.modTick(modTick), .modReset(modReset), .muxSelect(muxSelect),
	.gain_amplifier(gain_amplifier), .ampBypass(ampBypass),
	.intOscEnable(intOscEnable), .extClockSelected(extClockSelected)
);

`default_nettype wire

// ==== sdd_host_model.sv ====
`default_nettype none

module sdd_host_model (
	input  wire logic        clk,
	input  wire logic        rdyN,
	output var  logic        sclk,
	output var  logic [23:0] word,
	output var  int          wordCnt
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [23:0] sh;

	// ------
	// Host reader
	// ------
	// Clock idles low between frames
	initial begin
		sclk = 1'b0;
		word = 24'h0;
		wordCnt = 0;
		sh = 24'h0;
		forever begin
			@(negedge clk);
			if (rdyN === 1'b0) begin
				wordCnt++;
				for (int i = 0; i < 24; i++) begin
					sclk = 1'b1;
					repeat (3) @(negedge clk);
					sh = {sh[22:0], rdyN};
					@(negedge clk);
					sclk = 1'b0;
					repeat (4) @(negedge clk);
				end
				word = sh;
			end
		end
	end
endmodule // sdd_host_model

`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none

`define CHK(nm, ex, got) \
	begin \
		nTests++; \
		if ((got) !== (ex)) begin \
			fails++; \
			$display("unexpected %s: expected %h seen %h", nm, ex, got); \
		end \
	end

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int PS = 20;
	localparam int P1 = 77 * 64;
	localparam int P2 = 77 * 128;

	logic        clk = 1'b0;
	logic        rstN = 1'b0;
	logic        extOn = 1'b0;
	logic [4:0]  rate = 5'h13;
	logic [2:0]  chan = 3'h0;
	logic [2:0]  gain = 3'h0;
	logic [7:0]  timer = 8'h1;
	logic        pin = 1'b0;
	logic        modBit = 1'b1;
	logic [2:0]  div = 3'h0;
	logic        sclk;
	logic        rdyN;
	logic        modTick;
	logic        modReset;
	logic [2:0]  muxSel;
	logic [2:0]  gainAmp;
	logic        bypass;
	logic        intOsc;
	logic        extSel;
	logic [23:0] word;
	logic [23:0] w;
	int          wordCnt;
	int          n;
	int          fails = 0;
	int          nTests = 0;
	int          cyc = 0;

	sdd_rate_ctrl #(.PGA_SETTLE_CYC(PS), .TIMER_STEP_CYC(PS)) dut (
		.clk(clk), .arst_n(rstN), .word_rate_select(rate),
		.channelSel(chan), .gainSel(gain), .delayTimer(timer),
		.crystal_or_clock_in(pin), .modBit(modBit), .serialClkIn(sclk),
		.serial_out_ready_n(rdyN), .modTick(modTick), .modReset(modReset),
		.muxSelect(muxSel), .gain_amplifier(gainAmp), .ampBypass(bypass),
		.intOscEnable(intOsc), .extClockSelected(extSel)
	);

	sdd_host_model host (
		.clk(clk), .rdyN(rdyN), .sclk(sclk), .word(word), .wordCnt(wordCnt)
	);

	// ------
	// Clocks and ceiling
	// ------
	always #25 clk = ~clk;

	// External converter clock, 2.5 MHz
	always @(negedge clk) begin
		div <= div + 3'h1;
		pin <= extOn & div[2];
	end

	// Cycle ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			completeRun();
		end
	end

	// ------
	// Tasks
	// ------
	task automatic completeRun();
		if (fails == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Cycles until the host starts a frame
	task automatic waitWord(output int k);
		int c0;
		c0 = wordCnt;
		k = 0;
		while (wordCnt == c0 && k < 60000) begin
			@(posedge clk);
			k++;
		end
		@(negedge clk);
	endtask

	// New selection, then time to first word
	task automatic settle(input logic [2:0] c, input logic [2:0] g, input int p);
		int k;
		int b;
		chan = c;
		gain = g;
		b = PS + int'(timer) * PS + sdd_pkg::MIN_DELAY_CYC;
		waitWord(k);
		`CHK("settle", 1'b1, k >= b + 4 * p - p / 77 && k <= b + 4 * p + 300)
	endtask

	// ------
	// Sequence
	// ------
	initial begin
		repeat (16) @(negedge clk);
		`CHK("ready", 1'b1, rdyN)
		`CHK("osc", 1'b1, intOsc)
		`CHK("modreset", 1'b1, modReset)
		rstN = 1'b1;
		repeat (4100) @(negedge clk);
		`CHK("extsel", 1'b0, extSel)
		settle(3'h1, 3'h3, P1);
		`CHK("mux", 3'h1, muxSel)
		`CHK("gain", 3'h3, gainAmp)
		`CHK("bypass", 1'b0, bypass)
		waitWord(n);
		`CHK("period", P1, n)
		w = word;
		waitWord(n);
		`CHK("word", w, word)
		`CHK("msb", 1'b0, w[23])
		`CHK("nonzero", 1'b1, |w)
		rstN = 1'b0;
		extOn = 1'b1;
		timer = 8'h0;
		chan = 3'h0;
		gain = 3'h0;
		repeat (16) @(negedge clk);
		rstN = 1'b1;
		repeat (4100) @(negedge clk);
		`CHK("extsel", 1'b1, extSel)
		settle(3'h0, 3'h7, P2);
		for (int c = 4; c < 6; c++) begin
			chan = 3'(c);
			@(negedge clk);
			`CHK("mux", 3'(c), muxSel)
			`CHK("gain", 3'h0, gainAmp)
			`CHK("bypass", 1'b1, bypass)
		end
		completeRun();
	end
endmodule // tb_top

`default_nettype wire
